// *** rtl/alu_if.sv ***
// operand and result bundle between the top and the alu
`timescale 1ns/1ps
interface alu_if;
  logic [1:0] op;
  logic [7:0] operand;
  logic [7:0] result;
  logic carry_out;
  logic carry_we;
  logic zero_out;
  logic zero_we;
  modport core (output op, output operand,
    input result, input carry_out, input carry_we,
    input zero_out, input zero_we);
  modport alu (input op, input operand,
    output result, output carry_out, output carry_we,
    output zero_out, output zero_we);
endinterface

// *** rtl/shift_move_alu.sv ***
// combinational result and flag logic for shift and move
`timescale 1ns/1ps
module shift_move_alu
  import shift_move_pkg::*;
(
  alu_if.alu a
);
  always_comb begin
    a.result = a.operand;
    a.carry_out = 1'b0;
    a.carry_we = 1'b0;
    a.zero_we = 1'b0;
    case (a.op)
      OP_SHL: begin
        a.result = {a.operand[6:0], 1'b0};
        a.carry_out = a.operand[7];
        a.carry_we = 1'b1;
        a.zero_we = 1'b1;
      end
      OP_SHR: begin
        a.result = {1'b0, a.operand[7:1]};
        a.carry_out = a.operand[0];
        a.carry_we = 1'b1;
        a.zero_we = 1'b1;
      end
      OP_MOV: begin
        a.result = a.operand;
        a.zero_we = 1'b1;
      end
      default: begin
        a.result = a.operand;
      end
    endcase
    a.zero_out = (a.result == 8'h00);
  end
endmodule

// *** rtl/shift_move_datapath.sv ***
// shift left, shift right and move-file datapath with accumulator and flags
`timescale 1ns/1ps
module shift_move_datapath
  import shift_move_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // instruction from decoder
  input wire logic EXEC,
  input wire logic [1:0] OP,
  input wire logic DEST,
  input wire logic [6:0] FILE_ADDR,
  input wire logic [7:0] FILE_DATA,
  // file register write-back
  output logic FILE_WE,
  output logic [6:0] FILE_WADDR,
  output logic [7:0] FILE_WDATA,
  // core state
  output logic [7:0] ACC,
  output logic CARRY,
  output logic ZERO,
  output logic DONE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic zero;
    logic file_we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    phase_t phase;
  } state_t;

  state_t r;
  state_t next_r;
  alu_if a ();

  shift_move_alu alu_u (
    .a(a)
  );

  assign a.op = EXEC ? OP : OP_NONE;
  assign a.operand = FILE_DATA;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.file_we = 1'b0;
    next_r.phase = ST_IDLE;
    if (EXEC && OP != OP_NONE) begin
      next_r.phase = ST_DONE;
      if (DEST == DEST_ACC) begin
        next_r.acc = a.result;
      end else begin
        next_r.file_we = 1'b1;
        next_r.waddr = FILE_ADDR;
        next_r.wdata = a.result;
      end
      if (a.carry_we) begin
        next_r.carry = a.carry_out;
      end
      if (a.zero_we) begin
        next_r.zero = a.zero_out;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r <= '{acc: ACC_RESET, carry: CARRY_RESET, zero: ZERO_RESET,
             file_we: 1'b0, waddr: WADDR_RESET, wdata: WDATA_RESET,
             phase: ST_IDLE};
    end else begin
      r <= next_r;
    end
  end

  assign ACC = r.acc;
  assign CARRY = r.carry;
  assign ZERO = r.zero;
  assign FILE_WE = r.file_we;
  assign FILE_WADDR = r.waddr;
  assign FILE_WDATA = r.wdata;
  assign DONE = (r.phase == ST_DONE);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  chk_shl_carry: assert property (
    EXEC && OP == OP_SHL |=> CARRY == $past(FILE_DATA[7]))
    else $error("shift left carry wrong");
  chk_shl_result: assert property (
    EXEC && OP == OP_SHL && DEST == DEST_ACC
    |=> ACC == {$past(FILE_DATA[6:0]), 1'b0})
    else $error("shift left result wrong");
  chk_shl_file: assert property (
    EXEC && OP == OP_SHL && DEST == DEST_FILE
    |=> FILE_WE && FILE_WDATA == {$past(FILE_DATA[6:0]), 1'b0}
        && FILE_WADDR == $past(FILE_ADDR))
    else $error("shift left file write wrong");
  chk_mov_carry: assert property (
    EXEC && OP == OP_MOV |=> $stable(CARRY))
    else $error("move changed carry");
  chk_mov_dest: assert property (
    EXEC && OP == OP_MOV && DEST == DEST_FILE
    |=> FILE_WE && FILE_WDATA == $past(FILE_DATA) && $stable(ACC))
    else $error("move to file wrong");
  chk_mov_zero: assert property (
    EXEC && OP == OP_MOV |=> ZERO == ($past(FILE_DATA) == 8'h00))
    else $error("move zero flag wrong");
  chk_shr_all: assert property (
    EXEC && OP == OP_SHR && DEST == DEST_ACC
    |=> ACC == {1'b0, $past(FILE_DATA[7:1])}
        && CARRY == $past(FILE_DATA[0]))
    else $error("shift right wrong");
  chk_zero_flag: assert property (
    EXEC && OP == OP_SHL |=> ZERO == ($past(FILE_DATA[6:0]) == 7'h00))
    else $error("zero flag wrong");
  chk_idle_nowrite: assert property (
    !EXEC |=> !FILE_WE && !DONE)
    else $error("write without instruction");

  // ----------------------------------------
  // checks: destinations and flags
  // ----------------------------------------
  chk_shl_acc_only: assert property (
    EXEC && OP == OP_SHL && DEST == DEST_ACC |=> !FILE_WE)
    else $error("shift left to accumulator wrote file");
  chk_shl_file_acc: assert property (
    EXEC && OP == OP_SHL && DEST == DEST_FILE |=> $stable(ACC))
    else $error("shift left to file changed accumulator");
  chk_shl_file_zero: assert property (
    EXEC && OP == OP_SHL && DEST == DEST_FILE
    |=> ZERO == (FILE_WDATA == 8'h00))
    else $error("shift left to file zero flag wrong");
  chk_shr_file: assert property (
    EXEC && OP == OP_SHR && DEST == DEST_FILE
    |=> FILE_WE && FILE_WDATA == {1'b0, $past(FILE_DATA[7:1])}
        && FILE_WADDR == $past(FILE_ADDR) && $stable(ACC))
    else $error("shift right file write wrong");
  chk_shr_acc_only: assert property (
    EXEC && OP == OP_SHR && DEST == DEST_ACC |=> !FILE_WE)
    else $error("shift right to accumulator wrote file");
  chk_shr_carry: assert property (
    EXEC && OP == OP_SHR |=> CARRY == $past(FILE_DATA[0]))
    else $error("shift right carry wrong");
  chk_shr_zero: assert property (
    EXEC && OP == OP_SHR
    |=> ZERO == ($past(FILE_DATA[7:1]) == 7'h00))
    else $error("shift right zero flag wrong");
  chk_mov_acc: assert property (
    EXEC && OP == OP_MOV && DEST == DEST_ACC
    |=> ACC == $past(FILE_DATA) && !FILE_WE)
    else $error("move to accumulator wrong");
  chk_mov_waddr: assert property (
    EXEC && OP == OP_MOV && DEST == DEST_FILE
    |=> FILE_WADDR == $past(FILE_ADDR))
    else $error("move to file address wrong");
  chk_carry_only_shift: assert property (
    EXEC && OP != OP_SHL && OP != OP_SHR |=> $stable(CARRY))
    else $error("carry changed without a shift");
  chk_zero_dest: assert property (
    EXEC && OP != OP_NONE
    |=> ZERO == ($past(DEST) ? FILE_WDATA == 8'h00 : ACC == 8'h00))
    else $error("zero flag does not match destination");

  // ----------------------------------------
  // checks: handshake, refusal and reset
  // ----------------------------------------
  chk_done_pulse: assert property (
    EXEC && OP != OP_NONE |=> DONE)
    else $error("no done after operation");
  chk_done_idle: assert property (
    !(EXEC && OP != OP_NONE) |=> !DONE)
    else $error("done without operation");
  chk_we_done: assert property (
    FILE_WE |-> DONE)
    else $error("file write without done");
  chk_we_single: assert property (
    FILE_WE && !(EXEC && OP != OP_NONE && DEST == DEST_FILE)
    |=> !FILE_WE)
    else $error("file write longer than one cycle");
  chk_refused_op: assert property (
    EXEC && OP == OP_NONE
    |=> !DONE && !FILE_WE && $stable(ACC) && $stable(CARRY)
        && $stable(ZERO))
    else $error("empty operation changed state");
  chk_idle_hold: assert property (
    !EXEC |=> $stable(ACC) && $stable(CARRY) && $stable(ZERO)
        && $stable(FILE_WDATA) && $stable(FILE_WADDR))
    else $error("state changed without instruction");
  chk_reset_clear: assert property (disable iff (1'b0)
    SYS_RST |=> ACC == ACC_RESET && CARRY == CARRY_RESET
        && ZERO == ZERO_RESET && !FILE_WE && !DONE)
    else $error("reset did not clear state");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  cov_shl_file: cover property (EXEC && OP == OP_SHL && DEST);
  cov_shr_acc: cover property (EXEC && OP == OP_SHR && !DEST);
  cov_mov_zero: cover property (EXEC && OP == OP_MOV && FILE_DATA == 8'h00);
  cov_mov_file: cover property (EXEC && OP == OP_MOV && DEST);
  cov_refused: cover property (EXEC && OP == OP_NONE);
endmodule

// *** rtl/shift_move_pkg.sv ***
// shared constants and types for the shift/move datapath
package shift_move_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_SHL = 2'h1;
  localparam logic [1:0] OP_SHR = 2'h2;
  localparam logic [1:0] OP_MOV = 2'h3;
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'h0;
  localparam logic ZERO_RESET = 1'h0;
  localparam logic [6:0] WADDR_RESET = 7'h00;
  localparam logic [7:0] WDATA_RESET = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DONE = 2'b01
  } phase_t;
endpackage

// *** test/file_model.sv ***
// file register model: operand read and write-back
`timescale 1ns/1ps
module file_model (
  // clock
  input wire logic MCLK,
  // operand read
  input wire logic [6:0] FILE_ADDR,
  output logic [7:0] FILE_DATA,
  // write-back
  input wire logic FILE_WE,
  input wire logic [6:0] FILE_WADDR,
  input wire logic [7:0] FILE_WDATA
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = {i[6:0], i[0]};
  assign FILE_DATA = mem[FILE_ADDR];
  always @(posedge MCLK) if (FILE_WE) mem[FILE_WADDR] <= FILE_WDATA;
endmodule

// *** test/shift_move_datapath_tb.sv ***
// self-checking bench for the shift/move datapath
`timescale 1ns/1ps
module shift_move_datapath_tb;
  import shift_move_pkg::*;
  logic MCLK = 1'h0, SYS_RST = 1'h1, EXEC = 1'h0, DEST = 1'h0;
  logic [1:0] OP = 2'h0;
  logic [6:0] FILE_ADDR = 7'h00, FILE_WADDR, a;
  logic [7:0] FILE_DATA, ACC, FILE_WDATA, lfsr = 8'h48;
  logic FILE_WE, CARRY, ZERO, DONE;
  int mismatches = 0, compares = 0, cycles = 0;
  logic [7:0] exp_acc, exp_wd;
  logic [6:0] exp_wa;
  logic exp_c, exp_z;
  shift_move_datapath u_shift_move_datapath (.MCLK(MCLK),
    .SYS_RST(SYS_RST), .EXEC(EXEC), .OP(OP), .DEST(DEST),
    .FILE_ADDR(FILE_ADDR), .FILE_DATA(FILE_DATA), .FILE_WE(FILE_WE),
    .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA), .ACC(ACC),
    .CARRY(CARRY), .ZERO(ZERO), .DONE(DONE));
  file_model u_file_model (.MCLK(MCLK), .FILE_ADDR(FILE_ADDR),
    .FILE_DATA(FILE_DATA), .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR),
    .FILE_WDATA(FILE_WDATA));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] nxt(logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction
  function automatic logic [8:0] calc(logic [1:0] o, logic [7:0] v,
    logic ci);
    case (o)
      OP_SHL: return {v[7], v[6:0], 1'h0};
      OP_SHR: return {v[0], 1'h0, v[7:1]};
      default: return {ci, v};
    endcase
  endfunction
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: value %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: flag %b want %b", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset(int n);
    @(posedge MCLK);
    SYS_RST <= 1'h1;
    EXEC <= 1'h0;
    repeat (n) @(posedge MCLK);
    SYS_RST <= 1'h0;
    exp_acc = ACC_RESET;
    exp_c = CARRY_RESET;
    exp_z = ZERO_RESET;
    exp_wd = WDATA_RESET;
    exp_wa = WADDR_RESET;
    #1;
    chk8(ACC, exp_acc);
    chk1(CARRY, exp_c);
    chk1(ZERO, exp_z);
    chk1(DONE, 1'h0);
    chk1(FILE_WE, 1'h0);
    chk8(FILE_WDATA, exp_wd);
    chk8({1'h0, FILE_WADDR}, {1'h0, exp_wa});
  endtask
  task automatic run(logic [1:0] o, logic dd, logic [6:0] ad);
    logic [8:0] r;
    logic act;
    act = o != OP_NONE;
    @(posedge MCLK);
    OP <= o;
    DEST <= dd;
    FILE_ADDR <= ad;
    EXEC <= 1'h1;
    @(posedge MCLK);
    r = calc(o, FILE_DATA, exp_c);
    if (act) begin
      exp_c = r[8];
      exp_z = r[7:0] == 8'h00;
      if (dd) begin
        exp_wd = r[7:0];
        exp_wa = ad;
      end else begin
        exp_acc = r[7:0];
      end
    end
    EXEC <= 1'h0;
    #1;
    chk1(DONE, act);
    chk1(FILE_WE, act && dd);
    chk8(ACC, exp_acc);
    chk1(CARRY, exp_c);
    chk1(ZERO, exp_z);
    chk8(FILE_WDATA, exp_wd);
    chk8({1'h0, FILE_WADDR}, {1'h0, exp_wa});
  endtask
  // ----------------------------------------
  // clock, timeout, stimulus
  // ----------------------------------------
  initial forever #4 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    do_reset(9);
    run(OP_SHL, DEST_ACC, 7'h40);
    run(OP_MOV, DEST_FILE, 7'h00);
    run(OP_NONE, DEST_FILE, 7'h01);
    run(OP_SHR, DEST_FILE, 7'h01);
    run(OP_SHR, DEST_ACC, 7'h00);
    do_reset(2);
    for (int i = 0; i < 300; i++) begin
      lfsr = nxt(lfsr);
      a = lfsr[6:0];
      lfsr = nxt(lfsr);
      run(lfsr[1:0], lfsr[2], a);
    end
    end_sim();
  end
endmodule
